// ---- asram_ctrl.sv ----
// Host controller driving a 1K x 4 asynchronous static memory over its pins.
// Assumes one memory on the shared data lines; user requests on clk_sys_in.
`timescale 1ns/1ps
`default_nettype none

module asram_ctrl (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// User request
	input wire logic req_in,
	input wire logic write_in,
	input wire asram_pkg::asram_addr_type addr_in,
	input wire asram_pkg::asram_data_type wdata_in,
	output logic ready_out,
	// User answer
	output asram_pkg::asram_data_type rdata_out,
	output logic rvalid_out,
	// Memory pins
	output logic chip_sel_n_out,
	output logic write_strobe_n_out,
	output asram_pkg::asram_addr_type cell_sel_lines_out,
	output asram_pkg::asram_data_type mem_data_out,
	output logic mem_data_oe_out,
	input wire asram_pkg::asram_data_type mem_data_in
);
	import asram_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	asram_state_type state, next_state;
	asram_cnt_type cnt, next_cnt;
	logic next_chip_sel_n, next_write_strobe_n, next_mem_data_oe, next_rvalid;
	asram_addr_type next_cell_sel_lines;
	asram_data_type next_mem_data, next_rdata, data_sync;

	// ************************************************************
	// Pin input synchroniser
	// ************************************************************
	asram_sync #(
		.W(`ASRAM_DATA_W)
	) u_data_sync (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.d_in(mem_data_in),
		.q_out(data_sync)
	);

	assign ready_out = (state == ASRAM_IDLE);

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_chip_sel_n = chip_sel_n_out;
		next_write_strobe_n = write_strobe_n_out;
		next_cell_sel_lines = cell_sel_lines_out;
		next_mem_data = mem_data_out;
		next_mem_data_oe = mem_data_oe_out;
		next_rdata = rdata_out;
		next_rvalid = 1'h0;
		unique case (state)
			ASRAM_IDLE: begin
				next_cnt = 3'h0;
				if (req_in) begin
					next_cell_sel_lines = addr_in;
					next_chip_sel_n = 1'h0;
					if (write_in) begin
						// Both strobes fall together so the memory never drives
						next_write_strobe_n = 1'h0;
						next_mem_data = wdata_in;
						next_mem_data_oe = 1'h1;
						next_state = ASRAM_WRITE;
					end else begin
						next_write_strobe_n = 1'h1;
						next_state = ASRAM_READ;
					end
				end
			end
			ASRAM_READ: begin
				// Extra cycles cover the pin synchroniser
				if (cnt == 3'(`ASRAM_RD_CYC - 1)) begin
					next_rdata = data_sync;
					next_rvalid = 1'h1;
					next_chip_sel_n = 1'h1;
					next_cnt = 3'h0;
					next_state = ASRAM_TURN;
				end else begin
					next_cnt = cnt + 3'h1;
				end
			end
			ASRAM_WRITE: begin
				if (cnt == 3'(`ASRAM_WR_CYC - 1)) begin
					next_chip_sel_n = 1'h1;
					next_write_strobe_n = 1'h1;
					next_state = ASRAM_WEND;
				end else begin
					next_cnt = cnt + 3'h1;
				end
			end
			ASRAM_WEND: begin
				// Data held one cycle past the end of write
				next_mem_data_oe = 1'h0;
				next_state = ASRAM_IDLE;
			end
			ASRAM_TURN: begin
				// Memory may still drive the lines after deselect
				if (cnt == 3'(`ASRAM_HZ_CYC - 1)) begin
					next_state = ASRAM_IDLE;
				end else begin
					next_cnt = cnt + 3'h1;
				end
			end
			default: begin
				next_chip_sel_n = 1'h1;
				next_write_strobe_n = 1'h1;
				next_mem_data_oe = 1'h0;
				next_state = ASRAM_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state <= ASRAM_IDLE;
			cnt <= 3'h0;
			chip_sel_n_out <= `ASRAM_RST_CE_N;
			write_strobe_n_out <= `ASRAM_RST_WE_N;
			cell_sel_lines_out <= '0;
			mem_data_out <= '0;
			mem_data_oe_out <= 1'h0;
			rdata_out <= '0;
			rvalid_out <= 1'h0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			chip_sel_n_out <= next_chip_sel_n;
			write_strobe_n_out <= next_write_strobe_n;
			cell_sel_lines_out <= next_cell_sel_lines;
			mem_data_out <= next_mem_data;
			mem_data_oe_out <= next_mem_data_oe;
			rdata_out <= next_rdata;
			rvalid_out <= next_rvalid;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);

	a_read_strobe_high: assert property (
		(state == ASRAM_READ) |-> (!chip_sel_n_out && write_strobe_n_out && !mem_data_oe_out))
		else $error("read without strobe high or with host driving");
	a_read_cycle_len: assert property (
		($fell(chip_sel_n_out) && write_strobe_n_out) |-> (!chip_sel_n_out)[*4] ##1 chip_sel_n_out)
		else $error("read select width wrong");
	a_write_both_low: assert property (
		$fell(write_strobe_n_out) |-> $fell(chip_sel_n_out) && mem_data_oe_out)
		else $error("write did not start with both strobes");
	a_no_contention: assert property (
		$rose(mem_data_oe_out) |-> !write_strobe_n_out && $past(chip_sel_n_out, 2))
		else $error("host drives while memory may drive");
	a_addr_stable: assert property (
		(!chip_sel_n_out && !write_strobe_n_out && $past(!write_strobe_n_out))
		|-> $stable(cell_sel_lines_out))
		else $error("address moved during write");
	a_select_width: assert property (
		$fell(write_strobe_n_out) |-> (!chip_sel_n_out && !write_strobe_n_out)[*2]
		##1 (chip_sel_n_out && write_strobe_n_out))
		else $error("write pulse width wrong");
	a_data_hold: assert property (
		$rose(write_strobe_n_out) |-> mem_data_oe_out && $stable(mem_data_out)
		##1 !mem_data_oe_out)
		else $error("write data not held");
	a_data_setup: assert property (
		(!write_strobe_n_out) |-> mem_data_oe_out
		&& ($stable(mem_data_out) || $fell(write_strobe_n_out)))
		else $error("write data not driven through write");
	a_read_turn: assert property (
		(rvalid_out) |-> chip_sel_n_out && !mem_data_oe_out ##1 ready_out)
		else $error("no turnaround after read");
	a_turn_quiet: assert property (
		(state == ASRAM_TURN) |-> (chip_sel_n_out && !mem_data_oe_out))
		else $error("host drives during turnaround");
	a_write_end_joint: assert property (
		($rose(chip_sel_n_out) && $past(!write_strobe_n_out)) |-> write_strobe_n_out)
		else $error("write ended by one strobe only");

	c_read: cover property ($rose(rvalid_out));
	c_write: cover property ($rose(write_strobe_n_out));
	c_write_after_read: cover property (rvalid_out ##[1:4] $fell(write_strobe_n_out));
	c_refused: cover property (req_in && !ready_out);
endmodule : asram_ctrl

`default_nettype wire

// ---- asram_regs.svh ----
// Constants for the host end of a 1K x 4 asynchronous static memory.
// Assumes a 25 ns system clock; figures are for the slowest speed grade.
`ifndef ASRAM_REGS_SVH
`define ASRAM_REGS_SVH

// ************************************************************
// Pin widths
// ************************************************************
`define ASRAM_ADDR_W 10
`define ASRAM_DATA_W 4

// ************************************************************
// Timing in ns
// ************************************************************
`define ASRAM_CLK_NS 25
`define ASRAM_T_ACC_NS 45
`define ASRAM_T_HZ_NS 20
`define ASRAM_T_WP_NS 35
`define ASRAM_T_CW_NS 30
`define ASRAM_T_DW_NS 15

// ************************************************************
// Timing in clock cycles, least times rounded up
// ************************************************************
`define ASRAM_SYNC_CYC 2
`define ASRAM_ACC_CYC ((`ASRAM_T_ACC_NS + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS)
`define ASRAM_RD_CYC (`ASRAM_ACC_CYC + `ASRAM_SYNC_CYC)
`define ASRAM_HZ_CYC ((`ASRAM_T_HZ_NS + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS)
`define ASRAM_WR_CYC ((`ASRAM_T_WP_NS + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS)

// ************************************************************
// Reset values of the pins
// ************************************************************
`define ASRAM_RST_CE_N 1'h1
`define ASRAM_RST_WE_N 1'h1

`endif

// ---- asram_pkg.sv ----
// Types shared by the static memory host controller.
// Assumes asram_regs.svh is on the include path.
`include "asram_regs.svh"

package asram_pkg;
	typedef logic [`ASRAM_ADDR_W-1:0] asram_addr_type;
	typedef logic [`ASRAM_DATA_W-1:0] asram_data_type;
	typedef logic [2:0] asram_cnt_type;
	typedef enum logic [2:0] {
		ASRAM_IDLE = 3'b000,
		ASRAM_READ = 3'b001,
		ASRAM_WRITE = 3'b010,
		ASRAM_WEND = 3'b011,
		ASRAM_TURN = 3'b100
	} asram_state_type;
endpackage : asram_pkg

// ---- asram_sync.sv ----
// Two-stage synchroniser for a bus of pin inputs.
// Assumes the bus changes rarely relative to the clock or is sampled when settled.
`timescale 1ns/1ps
`default_nettype none

module asram_sync #(
	parameter int W = 4
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// Data
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta <= '0;
			q_out <= '0;
		end else begin
			meta <= d_in;
			q_out <= meta;
		end
	end
endmodule : asram_sync

`default_nettype wire

// ---- asram_mem_model.sv ----
// Behavioural 1K x 4 static memory for the host controller bench.
// Assumes bus_in is the resolved data wire built by the bench.
`timescale 1ns/1ps
`default_nettype none

module asram_mem_model (
	// Memory pins
	input wire logic chip_sel_n_in,
	input wire logic write_strobe_n_in,
	input wire asram_pkg::asram_addr_type cell_sel_lines_in,
	input wire asram_pkg::asram_data_type bus_in,
	// Drive onto the data lines
	output asram_pkg::asram_data_type data_out,
	output logic oe_out
);
	import asram_pkg::*;
	asram_data_type mem [0:1023];
	logic rd;
	logic wr;
	// Inertial delay drops zero-width glitches when both strobes move together
	assign #1 rd = !chip_sel_n_in && write_strobe_n_in;
	assign wr = !chip_sel_n_in && !write_strobe_n_in;
	initial begin
		oe_out = 1'b0;
		data_out = 4'h5;
	end
	always @(rd) oe_out <= #(rd ? 5 : 15) rd;
	// Inverted old word until the access time has run out
	always @(rd or cell_sel_lines_in) begin
		data_out = ~data_out;
		data_out <= #45 mem[cell_sel_lines_in];
	end
	always @(negedge wr) mem[cell_sel_lines_in] = bus_in;
endmodule : asram_mem_model
`default_nettype wire

// ---- asram_ctrl_tb.sv ----
// Self-checking bench for asram_ctrl against a behavioural memory.
// Assumes asram_pkg and asram_mem_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module asram_ctrl_tb;
	import asram_pkg::*;
	logic clk_sys_in = 1'b0;
	logic nrst_in = 1'b0;
	logic req_in = 1'b0;
	logic write_in = 1'b0;
	asram_addr_type addr_in = 10'h000;
	asram_data_type wdata_in = 4'h0;
	logic ready_out, rvalid_out, chip_sel_n_out, write_strobe_n_out, mem_data_oe_out, mdl_oe;
	asram_data_type rdata_out, mem_data_out, mdl_data, mem_bus;
	asram_data_type last = 4'h0;
	asram_addr_type cell_sel_lines_out;
	asram_addr_type adr [4] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa};
	asram_data_type dat [4] = '{4'ha, 4'h5, 4'hf, 4'h0};
	int failures = 0;
	int samples_checked = 0;
	realtime t_sel, t_dat;
	always #12.5 clk_sys_in = ~clk_sys_in;
	// Undriven lines show a changing pattern, never a held value
	assign mem_bus = mem_data_oe_out ? mem_data_out : (mdl_oe ? mdl_data : ~last);
	always @(posedge clk_sys_in) last <= mem_bus;
	asram_ctrl uut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .req_in(req_in),
		.write_in(write_in), .addr_in(addr_in), .wdata_in(wdata_in), .ready_out(ready_out),
		.rdata_out(rdata_out), .rvalid_out(rvalid_out), .chip_sel_n_out(chip_sel_n_out),
		.write_strobe_n_out(write_strobe_n_out), .cell_sel_lines_out(cell_sel_lines_out),
		.mem_data_out(mem_data_out), .mem_data_oe_out(mem_data_oe_out), .mem_data_in(mem_bus));
	asram_mem_model mdl (.chip_sel_n_in(chip_sel_n_out), .write_strobe_n_in(write_strobe_n_out),
		.cell_sel_lines_in(cell_sel_lines_out), .bus_in(mem_bus), .data_out(mdl_data),
		.oe_out(mdl_oe));
	task automatic finish_test;
		$display("compares %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test
	task automatic check_bit(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask : check_bit
	task automatic check_vec(input logic [9:0] got, input logic [9:0] exp, input string what);
		check_bit(got === exp, 1'b1, what);
	endtask : check_vec
	task automatic wait_ready;
		int n;
		n = 0;
		@(negedge clk_sys_in);
		while (ready_out !== 1'b1) begin
			n++;
			if (n > 50) begin
				check_bit(1'b0, 1'b1, "ready timeout");
				finish_test();
			end
			@(negedge clk_sys_in);
		end
	endtask : wait_ready
	// One request, then the pin walk until select is released
	task automatic access(input logic w, input asram_addr_type a, input asram_data_type d);
		int n;
		int low;
		wait_ready();
		@(posedge clk_sys_in);
		req_in <= 1'b1;
		write_in <= w;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_sys_in);
		req_in <= 1'b0;
		low = 0;
		for (n = 0; n < 12 && !(low > 0 && chip_sel_n_out === 1'b1); n++) begin
			@(negedge clk_sys_in);
			if (chip_sel_n_out === 1'b0) begin
				low++;
				check_vec(cell_sel_lines_out, a, "address");
				check_bit(write_strobe_n_out, !w, "strobe");
				check_bit(mem_data_oe_out, w, "drive");
				if (w) check_vec({6'h00, mem_data_out}, {6'h00, d}, "wdata");
			end
		end
		if (n >= 12) begin
			check_bit(1'b0, 1'b1, "select timeout");
			finish_test();
		end
		check_vec(10'(low), w ? 10'h002 : 10'h004, "select length");
		if (w) begin
			check_bit(mem_data_oe_out, 1'b1, "data hold");
		end else begin
			check_bit(rvalid_out, 1'b1, "rvalid");
			check_vec({6'h00, rdata_out}, {6'h00, d}, "rdata");
		end
	endtask : access
	// Requests while busy must be dropped
	task automatic refused;
		int n;
		wait_ready();
		@(posedge clk_sys_in);
		req_in <= 1'b1;
		write_in <= 1'b0;
		addr_in <= 10'h3ff;
		@(posedge clk_sys_in);
		write_in <= 1'b1;
		addr_in <= 10'h2aa;
		wdata_in <= 4'hc;
		@(negedge clk_sys_in);
		check_bit(ready_out, 1'b0, "busy");
		check_vec(cell_sel_lines_out, 10'h3ff, "busy address");
		@(posedge clk_sys_in);
		@(posedge clk_sys_in);
		req_in <= 1'b0;
		n = 0;
		while (rvalid_out !== 1'b1 && n < 8) begin
			@(negedge clk_sys_in);
			n++;
		end
		if (n >= 8) begin
			check_bit(1'b0, 1'b1, "rvalid timeout");
			finish_test();
		end
		check_vec({6'h00, rdata_out}, {6'h00, 4'h5}, "busy rdata");
		access(1'b0, 10'h2aa, 4'h0);
	endtask : refused
	always @(negedge chip_sel_n_out) t_sel = $realtime;
	always @(mem_data_out) t_dat = $realtime;
	always @(posedge write_strobe_n_out) if (nrst_in) begin
		check_bit($realtime - t_sel >= 30.0, 1'b1, "select before end");
		check_bit($realtime - t_dat >= 15.0, 1'b1, "data set-up");
	end
	always @(negedge clk_sys_in) if (mem_data_oe_out === 1'b1 && mdl_oe === 1'b1)
		check_bit(1'b0, 1'b1, "contention");
	initial begin
		repeat (16) @(posedge clk_sys_in);
		check_bit(chip_sel_n_out, 1'b1, "select in reset");
		check_bit(mem_data_oe_out, 1'b0, "drive in reset");
		nrst_in <= 1'b1;
		for (int i = 0; i < 4; i++) access(1'b1, adr[i], dat[i]);
		for (int i = 0; i < 4; i++) access(1'b0, adr[i], dat[i]);
		access(1'b1, 10'h155, 4'h3);
		access(1'b0, 10'h155, 4'h3);
		refused();
		finish_test();
	end
endmodule : asram_ctrl_tb
`default_nettype wire
